// ### design/prog_link.sv
// Bit engine for the two programming pins: makes the serial clock
// by division of aclk, shifts words out LSB first, samples replies.
// Assumes go only while idle; the data pin is resolved by the bench.
`timescale 1ns/10ps
`default_nettype none
module prog_link (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request from sequencer
  input wire logic [7:0] half_cyc,
  input wire logic go,
  input wire logic [4:0] nbits,
  input wire logic [23:0] dat,
  input wire logic drive,
  output logic done,
  output logic [15:0] cap,
  // Programming pins
  output logic prog_clock_pin,
  output logic prog_data_out,
  output logic prog_data_oe_n,
  input wire logic prog_data_in
);
  import serial_prog_pkg::*;

  typedef enum logic [1:0] {L_IDLE, L_HIGH, L_LOW} link_st_e;
  typedef struct packed {
    link_st_e st;
    logic [7:0] cnt;
    logic [4:0] left;
    logic [23:0] sh;
    logic drv;
    logic [15:0] cap;
    logic clk;
    logic dout;
    logic oe_n;
    logic done;
    logic s1;
    logic s2;
  } link_s;

  link_s q, d;

  // --------------------------------
  // Clock generation and shifting
  // --------------------------------
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.s1 = prog_data_in;
    d.s2 = q.s1;
    case (q.st)
      L_IDLE: begin
        if (go) begin
          d.st = L_HIGH;
          d.clk = 1'b1;
          d.cnt = 8'h01;
          d.left = nbits;
          d.sh = dat;
          d.drv = drive;
        end
      end
      L_HIGH: begin
        // Change data one cycle after the rise, never with it R10 R21
        if (q.cnt == 8'h01) begin
          d.oe_n = !q.drv;
          d.dout = q.drv ? q.sh[0] : q.dout; // R11
        end
        if (q.cnt >= half_cyc) begin
          d.st = L_LOW;
          d.clk = 1'b0;
          d.cnt = 8'h01;
        end else begin
          d.cnt = q.cnt + 8'h01;
        end
      end
      L_LOW: begin
        if (q.cnt >= half_cyc) begin
          // Late in the low phase, so the synchroniser has settled R21
          if (!q.drv) begin
            d.cap = {q.s2, q.cap[15:1]};
          end
          d.sh = {1'b0, q.sh[23:1]};
          d.left = q.left - 5'h01;
          d.cnt = 8'h01;
          if (q.left == 5'h01) begin
            d.st = L_IDLE;
            d.done = 1'b1;
          end else begin
            d.st = L_HIGH;
            d.clk = 1'b1;
          end
        end else begin
          d.cnt = q.cnt + 8'h01;
        end
      end
      default: d.st = L_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;
  assign cap = q.cap;
  assign prog_clock_pin = q.clk;
  assign prog_data_out = q.dout;
  assign prog_data_oe_n = q.oe_n;

  chk_drive_after_rise: assert property ( // R10
    @(posedge aclk) disable iff (!aresetn)
    $fell(prog_data_oe_n) |-> (prog_clock_pin && $past(prog_clock_pin))
  ) else $error("data pin driven in the cycle of a clock rise");
endmodule
`default_nettype wire

// ### design/serial_prog_host.sv
// Programming host: AXI4-Lite registers steer a sequencer that sends
// control codes and instruction words to the target over two pins.
// Assumes the target has been put in serial mode by other means.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1: Target idles waiting for 4-bit code
// R2: Code 0 executes, 1 views, others never sent
// R3: Target takes 24 clocks of instruction bits
// R4: Next code shifts in while instruction executes
// R5: First code after entry is 9 zero bits
// R6: Then 24 clocks load first real instruction
// R7: Table reads and writes followed by a NOP
// R8: View: eight idle clocks, then 16 data clocks
// R9: Host releases data pin during view output
// R10: Target drives data until next clock rise
// R11: Codes and words go LSB first
// R12: Program memory erased before it is written
// R13: After each write cycle, jump 0x100 then NOP
// R14: Unlock with 0x55 then 0xAA key writes
// R15: Set start bit, time, clear, with NOPs
// R16: Bulk erase value 0x407F, timed 2 ms
// R17: Segment erase uses its own control value
// R18: Configuration registers written one per cycle
// R19: Some parts clear boot config first, page 0xF8
// R20: Data memory read via page 0x7F, 16-bit words
// R21: Data changes on rise, sampled on fall
// R22: Reserved code leaves target idle
module serial_prog_host #(
  parameter int WAIT_CYC = serial_prog_pkg::WR_WAIT_CYC,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Programming pins
  output logic prog_clock_pin,
  output logic prog_data_out,
  output logic prog_data_oe_n,
  input wire logic prog_data_in
);
  import serial_prog_pkg::*;

  typedef enum logic [2:0] {
    T_IDLE, T_CODE, T_INSTR, T_VPROC, T_VDATA, T_WAIT
  } seq_st_e;

  typedef struct packed {
    seq_st_e st;
    logic macro;
    logic [4:0] step;
    logic [23:0] word;
    logic [3:0] code;
    logic nopfix;
    logic [31:0] wcnt;
    logic first;
    logic refused;
    logic erased;
    logic [23:0] instr;
    logic [15:0] nvm;
    logic [8:0] page;
    logic [7:0] div;
    logic [15:0] view;
    logic lk_go;
    logic [4:0] lk_n;
    logic [23:0] lk_dat;
    logic lk_drv;
    logic aw_got;
    logic [7:0] aw_a;
    logic w_got;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } seq_s;

  seq_s q, d;
  logic lk_done;
  logic [15:0] lk_cap;
  logic wr_fire;
  logic wr_cmd;
  logic sc;
  logic [3:0] sc_code;
  logic [31:0] m;
  logic [7:0] ra;

  // --------------------------------
  // Helpers
  // --------------------------------
  function automatic logic [23:0] mov_lit(input logic [15:0] lit,
                                          input logic [3:0] wreg);
    return {MOV_LIT_OP, lit, wreg};
  endfunction

  function automatic logic is_table(input logic [23:0] w);
    return (w[23:16] == TBL_RD_OP) || (w[23:16] == TBL_WR_OP);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // One write cycle as the target sees it
  function automatic logic [23:0] step_word(input logic [4:0] s,
                                            input logic [15:0] v,
                                            input logic [7:0] pg);
    case (s)
      5'h00: step_word = mov_lit({8'h00, pg}, REG_W0); // R19 R20
      5'h01: step_word = I_MOV_W0_PAGE;
      5'h02: step_word = mov_lit(v, REG_W10); // R16 R17
      5'h03: step_word = I_MOV_W10_NVM;
      5'h04: step_word = mov_lit(KEY_FIRST, REG_W8); // R14
      5'h05: step_word = I_MOV_W8_KEY;
      5'h06: step_word = mov_lit(KEY_SECOND, REG_W9);
      5'h07: step_word = I_MOV_W9_KEY;
      5'h08: step_word = I_BSET_WR; // R15
      5'h0E: step_word = I_BCLR_WR;
      5'h11: step_word = I_GOTO100; // R13 R18
      default: step_word = I_NOP;
    endcase
  endfunction

  // --------------------------------
  // Bus handshakes
  // --------------------------------
  // One write and one read in flight; readies drop while answering
  assign awready = !q.aw_got && !q.bvalid;
  assign wready = !q.w_got && !q.bvalid;
  assign arready = !q.rvalid;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign wr_fire = q.aw_got && q.w_got;
  assign wr_cmd = wr_fire && (q.aw_a == OFS_CMD);
  assign ra = araddr[7:0];

  // --------------------------------
  // Next state
  // --------------------------------
  always_comb begin
    d = q;
    sc = 1'b0;
    sc_code = CODE_EXEC;
    m = 32'h00000000;
    d.lk_go = 1'b0;
    if (awvalid && awready) begin
      d.aw_got = 1'b1;
      d.aw_a = awaddr[7:0];
    end
    if (wvalid && wready) begin
      d.w_got = 1'b1;
      d.w_d = wdata;
      d.w_s = wstrb;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 32'h00000000;
      if (ra == OFS_CMD) begin
        d.rdata = 32'h00000000;
      end else if (ra == OFS_INSTR) begin
        d.rdata = {8'h00, q.instr};
      end else if (ra == OFS_NVM) begin
        d.rdata = {16'h0000, q.nvm};
      end else if (ra == OFS_PAGE) begin
        d.rdata = {23'h000000, q.page};
      end else if (ra == OFS_STAT) begin
        d.rdata = {28'h0000000, q.erased, q.first, q.refused, q.st != T_IDLE};
      end else if (ra == OFS_VIEW) begin
        d.rdata = {16'h0000, q.view}; // R20
      end else if (ra == OFS_DIV) begin
        d.rdata = {24'h000000, q.div};
      end else begin
        d.rresp = RESP_DECERR;
      end
    end
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (q.aw_a == OFS_CMD) begin
        d.bresp = RESP_OKAY;
      end else if (q.aw_a == OFS_INSTR) begin
        m = merge({8'h00, q.instr}, q.w_d, q.w_s);
        d.instr = m[23:0];
      end else if (q.aw_a == OFS_NVM) begin
        m = merge({16'h0000, q.nvm}, q.w_d, q.w_s);
        d.nvm = m[15:0];
      end else if (q.aw_a == OFS_PAGE) begin
        m = merge({23'h000000, q.page}, q.w_d, q.w_s);
        d.page = m[8:0];
      end else if (q.aw_a == OFS_STAT) begin
        if (q.w_d[STAT_REFUSED] && q.w_s[0]) begin
          d.refused = 1'b0;
        end
      end else if (q.aw_a == OFS_DIV) begin
        if (q.w_s[0]) begin
          // Below two cycles the sampling point would outrun the synchroniser
          d.div = (q.w_d[7:0] < DIV_MIN) ? DIV_MIN : q.w_d[7:0];
        end
      end else begin
        d.bresp = RESP_DECERR;
      end
    end
    case (q.st)
      T_IDLE: begin
        if (wr_cmd) begin
          if (q.w_d[CMD_ENTRY_BIT]) begin
            d.first = 1'b1;
            d.erased = 1'b0;
          end else if (q.w_d[CMD_MACRO_BIT]) begin
            d.macro = 1'b1;
            d.step = q.page[PAGE_EN_BIT] ? ST_PAGE : ST_NVM; // R19 R20
            d.word = step_word(d.step, q.nvm, q.page[7:0]);
            sc = 1'b1;
          end else if (q.w_d[3:0] == CODE_EXEC) begin
            d.macro = 1'b0;
            d.word = q.instr;
            sc = 1'b1;
          end else if (q.w_d[3:0] == CODE_VIEW && !q.first) begin
            // First code after entry must be an execute R5
            d.macro = 1'b0;
            sc = 1'b1;
            sc_code = CODE_VIEW;
          end else begin
            d.refused = 1'b1; // R2 R22
          end
        end
      end
      T_CODE: begin
        if (lk_done) begin
          d.lk_go = 1'b1;
          if (q.code == CODE_EXEC) begin
            d.st = T_INSTR;
            d.lk_n = INSTR_BITS; // R3 R6
            d.lk_dat = q.word;
            d.lk_drv = 1'b1;
          end else begin
            d.st = T_VPROC;
            d.lk_n = VPROC_BITS; // R8
            d.lk_dat = I_NOP;
            d.lk_drv = 1'b0; // R9
          end
        end
      end
      T_VPROC: begin
        if (lk_done) begin
          d.st = T_VDATA;
          d.lk_go = 1'b1;
          d.lk_n = VIEW_BITS; // R8
          d.lk_drv = 1'b0;
        end
      end
      T_VDATA: begin
        if (lk_done) begin
          d.view = lk_cap;
          d.st = T_IDLE;
        end
      end
      T_INSTR: begin
        if (lk_done) begin
          if (is_table(q.word) && !q.nopfix) begin
            d.nopfix = 1'b1; // R7
            d.word = I_NOP;
            sc = 1'b1;
          end else begin
            d.nopfix = 1'b0;
            if (!q.macro) begin
              d.st = T_IDLE;
            end else if (q.step == ST_LAST) begin
              d.st = T_IDLE;
              if (q.nvm == NVM_BULK) begin
                d.erased = 1'b1; // R12
              end
            end else if (q.step + 5'h01 == ST_WAIT) begin
              d.step = ST_WAIT;
              d.st = T_WAIT;
              d.wcnt = 32'(WAIT_CYC - 1); // R15 R16
            end else begin
              d.step = q.step + 5'h01;
              d.word = step_word(d.step, q.nvm, q.page[7:0]);
              sc = 1'b1;
            end
          end
        end
      end
      T_WAIT: begin
        // Erase and write are timed here, not by the target
        if (q.wcnt == 32'h00000000) begin
          d.step = ST_RESUME;
          d.word = step_word(ST_RESUME, q.nvm, q.page[7:0]);
          sc = 1'b1;
        end else begin
          d.wcnt = q.wcnt - 32'h00000001; // R16
        end
      end
      default: d.st = T_IDLE;
    endcase
    if (sc) begin
      d.st = T_CODE;
      d.code = sc_code;
      d.lk_go = 1'b1;
      d.lk_drv = 1'b1;
      d.lk_dat = {20'h00000, sc_code}; // R11
      d.lk_n = (q.first && sc_code == CODE_EXEC) ? FIRST_BITS : CODE_BITS; // R5
      if (sc_code == CODE_EXEC) begin
        d.first = 1'b0;
      end
    end
    // A command while busy is dropped and flagged; set beats clear
    if (wr_cmd && q.st != T_IDLE) begin
      d.refused = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.div <= DIV_RST;
    end else begin
      q <= d;
    end
  end

  // --------------------------------
  // Pin engine
  // --------------------------------
  prog_link u_link (
    .aclk(aclk),
    .aresetn(aresetn),
    .half_cyc(q.div),
    .go(q.lk_go),
    .nbits(q.lk_n),
    .dat(q.lk_dat),
    .drive(q.lk_drv),
    .done(lk_done),
    .cap(lk_cap),
    .prog_clock_pin(prog_clock_pin),
    .prog_data_out(prog_data_out),
    .prog_data_oe_n(prog_data_oe_n),
    .prog_data_in(prog_data_in)
  );

  // --------------------------------
  // Checks
  // --------------------------------
  chk_reserved_refused: assert property ( // R2
    @(posedge aclk) disable iff (!aresetn)
    (wr_cmd && q.st == T_IDLE && !q.w_d[CMD_ENTRY_BIT] && !q.w_d[CMD_MACRO_BIT]
      && q.w_d[3:0] > CODE_VIEW) |=> (q.st == T_IDLE && q.refused && !q.lk_go)
  ) else $error("reserved code was not refused");

  chk_first_nine: assert property ( // R5
    @(posedge aclk) disable iff (!aresetn)
    (q.lk_go && q.lk_n == FIRST_BITS) |-> (q.lk_dat == I_NOP && q.lk_drv && !q.first)
  ) else $error("forced first code malformed");

  chk_lsb_first: assert property ( // R11
    @(posedge aclk) disable iff (!aresetn)
    (q.lk_go && q.lk_drv) |-> ##2 (!prog_data_oe_n && prog_data_out == $past(q.lk_dat[0], 2))
  ) else $error("first bit on pin is not the LSB");

  chk_view_release: assert property ( // R9
    @(posedge aclk) disable iff (!aresetn)
    (q.st == T_VDATA) |-> prog_data_oe_n
  ) else $error("host drives data pin during view output");

  chk_view_len: assert property ( // R8
    @(posedge aclk) disable iff (!aresetn)
    $rose(q.st == T_VDATA) |-> (q.lk_go && q.lk_n == VIEW_BITS && !q.lk_drv
      && $past(q.st) == T_VPROC)
  ) else $error("view data phase started wrongly");

  chk_table_nop: assert property ( // R7
    @(posedge aclk) disable iff (!aresetn)
    (q.st == T_INSTR && lk_done && is_table(q.word) && !q.nopfix)
      |=> (q.st == T_CODE && q.word == I_NOP) ##1 (q.st == T_CODE)
  ) else $error("table instruction not followed by NOP");

  chk_key_order: assert property ( // R14
    @(posedge aclk) disable iff (!aresetn)
    (q.macro && q.st == T_INSTR && q.lk_go && q.step == ST_KEY2)
      |-> (q.lk_dat == I_MOV_W9_KEY && $past(q.step, 2) == ST_KEY2)
  ) else $error("second key write out of place");

  chk_wait_load: assert property ( // R16
    @(posedge aclk) disable iff (!aresetn)
    $rose(q.st == T_WAIT) |-> (q.wcnt == 32'(WAIT_CYC - 1) && q.step == ST_WAIT)
  ) else $error("write timer loaded wrongly");

  chk_wait_hold: assert property ( // R15
    @(posedge aclk) disable iff (!aresetn)
    (q.st == T_WAIT && q.wcnt != 32'h00000000) |=> (q.st == T_WAIT && !q.lk_go)
  ) else $error("write cycle left before its time");

  chk_pc_reset: assert property ( // R13
    @(posedge aclk) disable iff (!aresetn)
    (q.macro && q.st == T_INSTR && q.lk_go && q.step == ST_GOTO)
      |-> q.lk_dat == I_GOTO100
  ) else $error("program counter reset word missing");
endmodule
`default_nettype wire

// ### design/serial_prog_pkg.sv
// Constants shared by the serial programming host and its pin engine.
// Assumes a 25 MHz aclk and a target CPU fed 24-bit words serially.
`default_nettype none
package serial_prog_pkg;
  // --------------------------------
  // Timing
  // --------------------------------
  localparam int CLK_KHZ = 25000;
  localparam int WR_TIME_US = 2000;
  localparam int WR_WAIT_CYC = (WR_TIME_US * CLK_KHZ + 999) / 1000;
  localparam logic [7:0] DIV_RST = 8'h04;
  localparam logic [7:0] DIV_MIN = 8'h02;
  // --------------------------------
  // Register map and fields
  // --------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_NVM = 8'h08;
  localparam logic [7:0] OFS_PAGE = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_VIEW = 8'h14;
  localparam logic [7:0] OFS_DIV = 8'h18;
  localparam int CMD_MACRO_BIT = 4;
  localparam int CMD_ENTRY_BIT = 8;
  localparam int PAGE_EN_BIT = 8;
  localparam int STAT_REFUSED = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // --------------------------------
  // Control codes and bit counts
  // --------------------------------
  localparam logic [3:0] CODE_EXEC = 4'h0;
  localparam logic [3:0] CODE_VIEW = 4'h1;
  localparam logic [4:0] CODE_BITS = 5'h04;
  localparam logic [4:0] FIRST_BITS = 5'h09;
  localparam logic [4:0] INSTR_BITS = 5'h18;
  localparam logic [4:0] VPROC_BITS = 5'h08;
  localparam logic [4:0] VIEW_BITS = 5'h10;
  // --------------------------------
  // Target instruction words
  // --------------------------------
  localparam logic [23:0] I_NOP = 24'h000000;
  localparam logic [23:0] I_GOTO100 = 24'h040100;
  localparam logic [23:0] I_BSET_WR = 24'hA8E761;
  localparam logic [23:0] I_BCLR_WR = 24'hA9E761;
  localparam logic [23:0] I_MOV_W10_NVM = 24'h883B0A;
  localparam logic [23:0] I_MOV_W0_PAGE = 24'h880190;
  localparam logic [23:0] I_MOV_W8_KEY = 24'h883B38;
  localparam logic [23:0] I_MOV_W9_KEY = 24'h883B39;
  localparam logic [3:0] MOV_LIT_OP = 4'h2;
  localparam logic [3:0] REG_W0 = 4'h0;
  localparam logic [3:0] REG_W8 = 4'h8;
  localparam logic [3:0] REG_W9 = 4'h9;
  localparam logic [3:0] REG_W10 = 4'hA;
  localparam logic [15:0] KEY_FIRST = 16'h0055;
  localparam logic [15:0] KEY_SECOND = 16'h00AA;
  localparam logic [7:0] TBL_RD_OP = 8'hBA;
  localparam logic [7:0] TBL_WR_OP = 8'hBB;
  localparam logic [15:0] NVM_BULK = 16'h407F;
  // --------------------------------
  // Write-cycle macro steps
  // --------------------------------
  localparam logic [4:0] ST_PAGE = 5'h00;
  localparam logic [4:0] ST_NVM = 5'h02;
  localparam logic [4:0] ST_KEY2 = 5'h07;
  localparam logic [4:0] ST_WAIT = 5'h0B;
  localparam logic [4:0] ST_RESUME = 5'h0C;
  localparam logic [4:0] ST_GOTO = 5'h11;
  localparam logic [4:0] ST_LAST = 5'h12;
endpackage
`default_nettype wire

// ### tb/prog_target.sv
// Target model: decodes codes and words off the pins, logs executed words.
// Assumes the bench resolves the shared data wire.
`timescale 1ns/10ps
`default_nettype none
module prog_target (
  // Pins
  input wire logic pclk,
  input wire logic pdat,
  output logic tdat,
  output logic tdrv,
  // Bench side
  input wire logic enter,
  input wire logic [15:0] view,
  output logic [23:0] log_q [32],
  output var int n_exec,
  output var int n_rsv
);
  typedef enum logic [2:0] {FIRST, CODE, INSTR, VPROC, VOUT} phase_e;
  phase_e ph = FIRST;
  logic [23:0] sh = '0;
  int n = 0;
  always @(negedge pclk or posedge enter) begin
    if (enter) begin
      ph = FIRST;
      n = 0;
      n_exec = 0;
      n_rsv = 0;
    end else begin
      sh = {pdat, sh[23:1]};
      n++;
      case (ph)
        FIRST: begin
          n_rsv += pdat;
          if (n == 9) begin
            ph = INSTR;
            n = 0;
          end
        end
        CODE: if (n == 4) begin
          n = 0;
          if (sh[23:20] == 4'h0) ph = INSTR;
          else if (sh[23:20] == 4'h1) ph = VPROC;
          else n_rsv++;
        end
        INSTR: if (n == 24) begin
          log_q[n_exec % 32] = sh;
          n_exec++;
          ph = CODE;
          n = 0;
        end
        VPROC: if (n == 8) begin
          ph = VOUT;
          n = 0;
        end
        default: if (n == 16) begin
          ph = CODE;
          n = 0;
        end
      endcase
    end
  end
  // Released line toggles so a stale level never reads as data
  always @(posedge pclk or posedge enter) begin
    if (enter) begin
      tdrv <= 1'h0;
      tdat <= 1'h0;
    end else if (ph == VOUT) begin
      tdrv <= 1'h1;
      tdat <= view[n];
    end else begin
      tdrv <= 1'h0;
      tdat <= ~tdat;
    end
  end
endmodule
`default_nettype wire

// ### tb/serial_prog_host_bench.sv
// Bench for the programming host: bus tasks, target model, scenarios.
// Assumes prog_target stands on the two pins.
`timescale 1ns/10ps
`default_nettype none
module serial_prog_host_bench;
  import serial_prog_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0, enter = 0, awready, wready, bvalid, arready, rvalid;
  logic prog_clock_pin, prog_data_out, prog_data_oe_n, prog_data_in, tdat, tdrv;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, q;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, r;
  logic [15:0] view = '0;
  logic [23:0] log_q [32];
  int n_exec, n_rsv, n_errors = 0, checks = 0, cyc = 0;
  always #20 aclk = ~aclk;
  assign prog_data_in = prog_data_oe_n ? tdat : prog_data_out;
  serial_prog_host #(.WAIT_CYC(20)) dut (.*);
  prog_target tgt (.pclk(prog_clock_pin), .pdat(prog_data_in), .tdat(tdat), .tdrv(tdrv),
    .enter(enter), .view(view), .log_q(log_q), .n_exec(n_exec), .n_rsv(n_rsv));
  task automatic close_out;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, fin;
    fin = 0;
    @(posedge aclk);
    awvalid <= we;
    wvalid <= we;
    bready <= we;
    arvalid <= !we;
    rready <= !we;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    // No local limit: a silent slave is caught by the cycle ceiling
    while (!fin) begin
      @(negedge aclk);
      ta = we ? awvalid && awready : arvalid && arready;
      tw = wvalid && wready;
      fin = we ? bvalid : rvalid;
      q = rdata;
      r = we ? bresp : rresp;
      @(posedge aclk);
      awvalid <= awvalid && !ta;
      arvalid <= arvalid && !ta;
      wvalid <= wvalid && !tw;
      bready <= bready && !fin;
      rready <= rready && !fin;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'h0, a, 32'h0);
  endtask
  // Polls busy; the cycle ceiling catches a hang
  task automatic idle;
    do rd(OFS_STAT);
    while (q[0] !== 1'h0);
  endtask
  task automatic t_regs;
    rd(OFS_STAT);
    chk(q, 32'h0);
    wr(OFS_DIV, 32'h1);
    rd(OFS_DIV);
    chk(q, {24'h0, DIV_MIN});
    wr(OFS_DIV, {24'h0, DIV_RST});
    rd(8'h1C);
    chk(r, RESP_DECERR);
    wr(8'h1C, 32'h0);
    chk(r, RESP_DECERR);
    wstrb <= 4'h1;
    wr(OFS_INSTR, 32'hFFFFFF);
    wstrb <= 4'hF;
    rd(OFS_INSTR);
    chk(q, 32'h000000FF);
  endtask
  task automatic t_first;
    enter <= 1'h1;
    wr(OFS_CMD, 32'h100);
    enter <= 1'h0;
    wr(OFS_CMD, 32'h1);
    rd(OFS_STAT);
    chk(q[2:1], 2'h3);
    wr(OFS_STAT, 32'h2);
    wr(OFS_INSTR, 32'hABCDEF);
    wr(OFS_CMD, 32'h0);
    wr(OFS_CMD, 32'h0);
    idle;
    chk(q[2:0], 3'h2);
    chk(n_exec, 1);
    chk(n_rsv, 0);
    chk(log_q[0], 24'hABCDEF);
  endtask
  task automatic t_table;
    wr(OFS_INSTR, 32'hBA1BB6);
    wr(OFS_CMD, 32'h0);
    idle;
    chk(n_exec, 3);
    chk(log_q[2], I_NOP);
  endtask
  task automatic t_reserved;
    for (int c = 2; c < 16; c++) begin
      wr(OFS_STAT, 32'h2);
      rd(OFS_STAT);
      chk(q[1], 1'h0);
      wr(OFS_CMD, c);
      rd(OFS_STAT);
      chk(q[1], 1'h1);
    end
    chk(n_rsv, 0);
  endtask
  task automatic t_view;
    logic [15:0] v [2];
    v = '{16'hA5C3, 16'h5A3C};
    foreach (v[i]) begin
      view = v[i];
      wr(OFS_CMD, 32'h1);
      idle;
      rd(OFS_VIEW);
      chk(q, {16'h0, v[i]});
    end
    chk(n_exec, 3);
  endtask
  task automatic t_macro;
    logic [23:0] m [18];
    m = '{{MOV_LIT_OP, 16'h00F8, REG_W0}, I_MOV_W0_PAGE, {MOV_LIT_OP, NVM_BULK, REG_W10},
      I_MOV_W10_NVM, {MOV_LIT_OP, KEY_FIRST, REG_W8}, I_MOV_W8_KEY,
      {MOV_LIT_OP, KEY_SECOND, REG_W9}, I_MOV_W9_KEY, I_BSET_WR, I_NOP, I_NOP, I_NOP, I_NOP,
      I_BCLR_WR, I_NOP, I_NOP, I_GOTO100, I_NOP};
    wr(OFS_PAGE, 32'h1F8);
    wr(OFS_NVM, {16'h0, NVM_BULK});
    wr(OFS_CMD, 32'h10);
    idle;
    chk(q[3], 1'h1);
    chk(n_exec, 21);
    foreach (m[i]) chk(log_q[i + 3], m[i]);
  endtask
  // Entry again, then a non-bulk cycle with the page load skipped
  task automatic t_segment;
    enter <= 1'h1;
    wr(OFS_CMD, 32'h100);
    enter <= 1'h0;
    wr(OFS_PAGE, 32'h0F8);
    wr(OFS_NVM, 32'h4008);
    wr(OFS_CMD, 32'h10);
    idle;
    chk(q[3:2], 2'h0);
    chk(n_exec, 16);
    chk(log_q[0], {MOV_LIT_OP, 16'h4008, REG_W10});
    chk(log_q[14], I_GOTO100);
    chk(n_rsv, 0);
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_first;
    t_table;
    t_reserved;
    t_view;
    t_macro;
    t_segment;
    close_out;
  end
  always @(negedge aclk) begin
    cyc++;
    if (tdrv && !prog_data_oe_n) chk(1, 0);
    if (cyc == 20000) begin
      n_errors++;
      close_out;
    end
  end
endmodule
`default_nettype wire
